// File: pkg/lds_pkg.sv
// Package: register map, supervisor constants and state types of the LED driver target port
package lds_pkg;
    localparam logic [6:0] TARGET_ADDR = 7'h45;
    localparam logic [7:0] REG_SOFT_RESET = 8'h00;
    localparam logic [7:0] REG_GLOBAL_CTRL1 = 8'h01;
    localparam logic [7:0] REG_EVENT_FLAGS = 8'h02;
    localparam logic [7:0] REG_GLOBAL_CTRL2 = 8'h04;
    localparam logic [7:0] SOFT_RESET_KEY = 8'h55;
    // Identity code read back at address 0x00; value is arbitrary
    localparam logic [7:0] CHIP_ID_DEFAULT = 8'h5a;
    localparam logic [7:0] GLOBAL_CTRL1_RESET = 8'h00;
    localparam logic [7:0] GLOBAL_CTRL2_RESET = 8'h00;
    localparam int ENABLE_BIT = 0;
    localparam int POWER_UP_FLAG_BIT = 4;
    localparam int UNDERVOLTAGE_FLAG_BIT = 3;
    localparam int OVERTEMP_FLAG_BIT = 2;
    localparam int UV_ACTION_OFF_BIT = 7;
    localparam int OT_ACTION_OFF_BIT = 6;
    localparam int UV_MONITOR_OFF_BIT = 5;
    localparam int OT_MONITOR_OFF_BIT = 4;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SCL_DEGLITCH_PS = 200000;
    localparam int SDA_DEGLITCH_PS = 250000;
    localparam int SCL_DEGLITCH_CYC = SCL_DEGLITCH_PS / CLK_PERIOD_PS;
    localparam int SDA_DEGLITCH_CYC = SDA_DEGLITCH_PS / CLK_PERIOD_PS;

    typedef enum logic [2:0] {
        LDS_IDLE = 3'b000,
        LDS_ADDR = 3'b001,
        LDS_ADDR_ACK = 3'b010,
        LDS_WR_BYTE = 3'b011,
        LDS_WR_ACK = 3'b100,
        LDS_RD_BYTE = 3'b101,
        LDS_RD_ACK = 3'b110,
        LDS_WAIT_STOP = 3'b111
    } lds_phase_t;

    typedef struct packed {
        logic uv_action_off;
        logic ot_action_off;
        logic uv_monitor_off;
        logic ot_monitor_off;
        logic [3:0] other;
    } lds_ctrl2_t;

    typedef struct packed {
        lds_phase_t phase;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] reg_addr;
        logic addr_phase;
        logic sda_drive;
        logic [7:0] ctrl1;
        lds_ctrl2_t ctrl2;
        logic [7:0] flags;
        logic uv_seen;
        logic ot_seen;
        logic por_done;
    } lds_state_t;
endpackage : lds_pkg

// File: hw/lds_filter.sv
// Two-flop synchroniser followed by a glitch filter for one bus line
module lds_filter #(
    parameter int HOLD_CYC = 40
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic pin_i,
    output logic level_o
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic level;
        logic [7:0] cnt;
    } lds_filt_state_t;

    lds_filt_state_t st_r;
    lds_filt_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = pin_i;
        st_nxt.sync = st_r.meta;
        // Accept a new level only after it has stood the full hold time
        if (st_r.sync == st_r.level) begin
            st_nxt.cnt = 8'h00;
        end else if (st_r.cnt >= 8'(HOLD_CYC - 1)) begin
            st_nxt.level = st_r.sync;
            st_nxt.cnt = 8'h00;
        end else begin
            st_nxt.cnt = st_r.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            st_r <= '{meta: 1'b1, sync: 1'b1, level: 1'b1, cnt: 8'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_o = st_r.level;

    level_hold_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $changed(st_r.level) |-> $past(st_r.cnt) >= 8'(HOLD_CYC - 1))
        else $error("line level taken before hold time");
endmodule // lds_filter

// File: hw/lds_target.sv
// Serial target port and operating-state supervisor of a three-channel LED driver
// Behaviour
// - Respond only to 7-bit address 0x45 followed by direction bit.
// - Detect start and stop as SDA edges while SCL high.
// - SDA change during SCL high mid-transaction abandons the transaction.
// - Bytes are eight bits, MSB first, each followed by an acknowledge slot.
// - After eight received bits the device pulls SDA low to acknowledge.
// - When sending, release SDA, sample master ack; nack means wait for stop.
// - Acknowledge address byte only on a matching target address.
// - Each written byte stored at current register address, then address increments.
// - Reads send current register, increment on each master acknowledge.
// - Target in fast mode, SCL up to 400 kHz from the master.
// - Power-on reset puts device in standby with registers at defaults.
// - Power-on reset sets power-up flag bit 4 of status; read clears it.
// - Clearing the enable bit in active mode returns to standby.
// - In standby only reset and first control register accept writes.
// - Writing enable to one in standby enters active and starts oscillator.
// - Writing 0x55 to address 0x00 resets logic and registers; the code resets both control registers and keeps only flag bits 3 and 2.
// - Undervoltage sets flag, clears enable, enters standby.
// - Undervoltage monitor-off and action-off bits, both reset to zero.
// - Over-temperature sets flag, clears enable, enters standby.
// - Over-temperature monitor-off and action-off bits, both reset to zero.
// - First control register at 0x01, reset value 0x00.
// - Second control register at 0x04 holds protection disables.
module lds_target #(
    parameter logic [6:0] TARGET_ADDR = lds_pkg::TARGET_ADDR
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic undervoltage_i,
    input wire logic overtemp_i,
    output logic active_o,
    output logic osc_run_o,
    output logic [7:0] global_control_first_o,
    output logic [7:0] global_control_second_o
);
    logic scl_f;
    logic sda_f;
    logic uv_m;
    logic uv_s;
    logic ot_m;
    logic ot_s;
    logic scl_d;
    logic sda_d;

    lds_filter #(.HOLD_CYC(lds_pkg::SCL_DEGLITCH_CYC)) u_scl_filt (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .pin_i(scl_i),
        .level_o(scl_f)
    );
    lds_filter #(.HOLD_CYC(lds_pkg::SDA_DEGLITCH_CYC)) u_sda_filt (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .pin_i(sda_i),
        .level_o(sda_f)
    );

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            uv_m <= 1'b0;
            uv_s <= 1'b0;
            ot_m <= 1'b0;
            ot_s <= 1'b0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            uv_m <= undervoltage_i;
            uv_s <= uv_m;
            ot_m <= overtemp_i;
            ot_s <= ot_m;
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise = scl_f && !scl_d;
    assign scl_fall = !scl_f && scl_d;
    assign start_det = scl_f && scl_d && sda_d && !sda_f;
    assign stop_det = scl_f && scl_d && !sda_d && sda_f;

    lds_pkg::lds_state_t st_r;
    lds_pkg::lds_state_t st_nxt;
    logic active;
    assign active = st_r.ctrl1[lds_pkg::ENABLE_BIT];

    function automatic logic [7:0] read_reg(input lds_pkg::lds_state_t s);
        case (s.reg_addr)
            lds_pkg::REG_SOFT_RESET: read_reg = lds_pkg::CHIP_ID_DEFAULT;
            lds_pkg::REG_GLOBAL_CTRL1: read_reg = s.ctrl1;
            lds_pkg::REG_EVENT_FLAGS: read_reg = s.flags;
            lds_pkg::REG_GLOBAL_CTRL2: read_reg = s.ctrl2;
            default: read_reg = 8'h00;
        endcase
    endfunction

    always_comb begin
        logic [7:0] rx;
        logic uv_event;
        logic ot_event;
        logic soft_reset;
        logic flags_read;
        rx = {st_r.shift[6:0], sda_f};
        uv_event = uv_s && !st_r.uv_seen && !st_r.ctrl2.uv_monitor_off;
        ot_event = ot_s && !st_r.ot_seen && !st_r.ctrl2.ot_monitor_off;
        soft_reset = 1'b0;
        flags_read = 1'b0;
        st_nxt = st_r;
        st_nxt.por_done = 1'b1;
        unique case (st_r.phase)
            lds_pkg::LDS_IDLE: begin
                st_nxt.sda_drive = 1'b0;
            end
            lds_pkg::LDS_ADDR, lds_pkg::LDS_WR_BYTE: begin
                if (scl_rise) begin
                    st_nxt.shift = rx;
                    st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                end
                if (scl_fall && st_r.bit_cnt == 4'h8) begin
                    st_nxt.bit_cnt = 4'h0;
                    if (st_r.phase == lds_pkg::LDS_ADDR) begin
                        if (st_r.shift[7:1] == TARGET_ADDR) begin
                            st_nxt.phase = lds_pkg::LDS_ADDR_ACK;
                            st_nxt.sda_drive = 1'b1;
                        end else begin
                            st_nxt.phase = lds_pkg::LDS_WAIT_STOP;
                        end
                    end else begin
                        st_nxt.phase = lds_pkg::LDS_WR_ACK;
                        st_nxt.sda_drive = 1'b1;
                    end
                end
            end
            lds_pkg::LDS_ADDR_ACK: begin
                if (scl_fall) begin
                    if (st_r.shift[0]) begin
                        st_nxt.phase = lds_pkg::LDS_RD_BYTE;
                        st_nxt.shift = read_reg(st_r);
                        st_nxt.sda_drive = !read_reg(st_r)[7];
                        flags_read = (st_r.reg_addr == lds_pkg::REG_EVENT_FLAGS);
                        st_nxt.bit_cnt = 4'h1;
                    end else begin
                        st_nxt.phase = lds_pkg::LDS_WR_BYTE;
                        st_nxt.sda_drive = 1'b0;
                        st_nxt.addr_phase = 1'b1;
                    end
                end
            end
            lds_pkg::LDS_WR_ACK: begin
                if (scl_fall) begin
                    st_nxt.sda_drive = 1'b0;
                    st_nxt.phase = lds_pkg::LDS_WR_BYTE;
                    if (st_r.addr_phase) begin
                        st_nxt.reg_addr = st_r.shift;
                        st_nxt.addr_phase = 1'b0;
                    end else begin
                        // Store then advance; standby admits only reset and control 1
                        unique case (st_r.reg_addr)
                            lds_pkg::REG_SOFT_RESET: soft_reset = (st_r.shift == lds_pkg::SOFT_RESET_KEY);
                            lds_pkg::REG_GLOBAL_CTRL1: st_nxt.ctrl1 = st_r.shift;
                            lds_pkg::REG_GLOBAL_CTRL2: if (active) st_nxt.ctrl2 = st_r.shift;
                            default: ;
                        endcase
                        st_nxt.reg_addr = st_r.reg_addr + 8'h01;
                    end
                end
            end
            lds_pkg::LDS_RD_BYTE: begin
                if (scl_fall) begin
                    if (st_r.bit_cnt == 4'h8) begin
                        st_nxt.sda_drive = 1'b0;
                        st_nxt.phase = lds_pkg::LDS_RD_ACK;
                    end else begin
                        st_nxt.sda_drive = !st_r.shift[3'(7 - st_r.bit_cnt)];
                        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                    end
                end
            end
            lds_pkg::LDS_RD_ACK: begin
                if (scl_rise) begin
                    if (sda_f) begin
                        st_nxt.phase = lds_pkg::LDS_WAIT_STOP;
                    end else begin
                        st_nxt.reg_addr = st_r.reg_addr + 8'h01;
                    end
                end
                if (scl_fall) begin
                    st_nxt.phase = lds_pkg::LDS_RD_BYTE;
                    st_nxt.shift = read_reg(st_r);
                    st_nxt.sda_drive = !read_reg(st_r)[7];
                    flags_read = (st_r.reg_addr == lds_pkg::REG_EVENT_FLAGS);
                    st_nxt.bit_cnt = 4'h1;
                end
            end
            lds_pkg::LDS_WAIT_STOP: begin
                st_nxt.sda_drive = 1'b0;
            end
        endcase
        if (start_det) begin
            st_nxt.phase = lds_pkg::LDS_ADDR;
            st_nxt.bit_cnt = 4'h0;
            st_nxt.sda_drive = 1'b0;
        end else if (stop_det) begin
            st_nxt.phase = lds_pkg::LDS_IDLE;
            st_nxt.sda_drive = 1'b0;
        end
        if (flags_read) begin
            st_nxt.flags = 8'h00;
        end
        st_nxt.uv_seen = uv_s && !st_r.ctrl2.uv_monitor_off;
        st_nxt.ot_seen = ot_s && !st_r.ctrl2.ot_monitor_off;
        if (uv_event) begin
            st_nxt.flags[lds_pkg::UNDERVOLTAGE_FLAG_BIT] = 1'b1;
            if (!st_r.ctrl2.uv_action_off) st_nxt.ctrl1[lds_pkg::ENABLE_BIT] = 1'b0;
        end
        if (ot_event) begin
            st_nxt.flags[lds_pkg::OVERTEMP_FLAG_BIT] = 1'b1;
            if (!st_r.ctrl2.ot_action_off) st_nxt.ctrl1[lds_pkg::ENABLE_BIT] = 1'b0;
        end
        // Condition still present keeps the device out of active
        if ((st_r.uv_seen && !st_r.ctrl2.uv_action_off) || (st_r.ot_seen && !st_r.ctrl2.ot_action_off)) begin
            st_nxt.ctrl1[lds_pkg::ENABLE_BIT] = 1'b0;
        end
        if (soft_reset) begin
            st_nxt.ctrl1 = lds_pkg::GLOBAL_CTRL1_RESET;
            st_nxt.ctrl2 = lds_pkg::GLOBAL_CTRL2_RESET;
            st_nxt.flags = st_nxt.flags & 8'h0c;
        end
        if (!st_r.por_done) begin
            st_nxt.flags[lds_pkg::POWER_UP_FLAG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_n_o = !st_r.sda_drive;
    assign active_o = active;
    assign osc_run_o = active;
    assign global_control_first_o = st_r.ctrl1;
    assign global_control_second_o = st_r.ctrl2;

    ack_drive_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (st_r.phase == lds_pkg::LDS_ADDR && scl_fall && st_r.bit_cnt == 4'h8 && !start_det && !stop_det
         && st_r.shift[7:1] != TARGET_ADDR) |=> !st_r.sda_drive)
        else $error("acknowledged a foreign address");
    ack_match_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (st_r.phase == lds_pkg::LDS_ADDR && scl_fall && st_r.bit_cnt == 4'h8 && !start_det && !stop_det
         && st_r.shift[7:1] == TARGET_ADDR) |=> st_r.sda_drive && st_r.phase == lds_pkg::LDS_ADDR_ACK)
        else $error("no acknowledge on own address");
    stop_idle_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (stop_det && !start_det) |=> st_r.phase == lds_pkg::LDS_IDLE && !st_r.sda_drive)
        else $error("stop did not end transaction");
    nack_wait_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (st_r.phase == lds_pkg::LDS_RD_ACK && scl_rise && sda_f && !start_det && !stop_det)
        |=> st_r.phase == lds_pkg::LDS_WAIT_STOP)
        else $error("kept sending after nack");
    rd_incr_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (st_r.phase == lds_pkg::LDS_RD_ACK && scl_rise && !sda_f && !start_det && !stop_det)
        |=> st_r.reg_addr == $past(st_r.reg_addr) + 8'h01)
        else $error("read address not advanced");
    enable_osc_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        osc_run_o == st_r.ctrl1[lds_pkg::ENABLE_BIT])
        else $error("oscillator not tied to enable");
    uv_standby_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (uv_s && !st_r.uv_seen && !st_r.ctrl2.uv_monitor_off && !st_r.ctrl2.uv_action_off)
        |=> !active_o && st_r.flags[lds_pkg::UNDERVOLTAGE_FLAG_BIT])
        else $error("undervoltage left device active");
    ot_standby_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (ot_s && !st_r.ot_seen && !st_r.ctrl2.ot_monitor_off && !st_r.ctrl2.ot_action_off)
        |=> !active_o && st_r.flags[lds_pkg::OVERTEMP_FLAG_BIT])
        else $error("overtemperature left device active");
    por_flag_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !st_r.por_done |=> st_r.flags[lds_pkg::POWER_UP_FLAG_BIT])
        else $error("power-up flag not set");

    // Byte engine and register side effects
    start_addr_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        start_det |=> st_r.phase == lds_pkg::LDS_ADDR && st_r.bit_cnt == 4'h0 && !st_r.sda_drive)
        else $error("start did not open address phase");
    bit_shift_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (st_r.phase == lds_pkg::LDS_WR_BYTE && scl_rise && !start_det && !stop_det)
        |=> st_r.shift == {$past(st_r.shift[6:0]), $past(sda_f)})
        else $error("received bit not shifted in");
    wr_ack_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (st_r.phase == lds_pkg::LDS_WR_BYTE && scl_fall && st_r.bit_cnt == 4'h8 && !start_det && !stop_det)
        |=> st_r.phase == lds_pkg::LDS_WR_ACK && st_r.sda_drive)
        else $error("no acknowledge after data byte");
    rd_release_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (st_r.phase == lds_pkg::LDS_RD_BYTE && scl_fall && st_r.bit_cnt == 4'h8 && !start_det && !stop_det)
        |=> st_r.phase == lds_pkg::LDS_RD_ACK && !st_r.sda_drive)
        else $error("data line not released for master acknowledge");
    rd_next_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (st_r.phase == lds_pkg::LDS_RD_ACK && scl_fall && !start_det && !stop_det)
        |=> st_r.phase == lds_pkg::LDS_RD_BYTE && st_r.bit_cnt == 4'h1)
        else $error("next read byte not started");
    wr_incr_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (st_r.phase == lds_pkg::LDS_WR_ACK && scl_fall && !st_r.addr_phase && !start_det && !stop_det)
        |=> st_r.reg_addr == $past(st_r.reg_addr) + 8'h01)
        else $error("write address not advanced");
    ctrl1_store_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (st_r.phase == lds_pkg::LDS_WR_ACK && scl_fall && !st_r.addr_phase
         && st_r.reg_addr == lds_pkg::REG_GLOBAL_CTRL1 && !start_det && !stop_det)
        |=> st_r.ctrl1[7:1] == $past(st_r.shift[7:1]) && ($past(st_r.shift[0]) || !active_o))
        else $error("control 1 write not taken");
    flags_clear_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (st_r.phase == lds_pkg::LDS_ADDR_ACK && scl_fall && st_r.shift[0] && st_r.por_done
         && st_r.reg_addr == lds_pkg::REG_EVENT_FLAGS && !start_det && !stop_det)
        |=> !st_r.flags[lds_pkg::POWER_UP_FLAG_BIT])
        else $error("power-up flag kept after status read");
    standby_ctrl2_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (!active && st_r.phase == lds_pkg::LDS_WR_ACK && scl_fall && !st_r.addr_phase
         && st_r.reg_addr == lds_pkg::REG_GLOBAL_CTRL2 && !start_det && !stop_det)
        |=> $stable(st_r.ctrl2))
        else $error("control 2 written in standby");
    soft_reset_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (st_r.phase == lds_pkg::LDS_WR_ACK && scl_fall && !st_r.addr_phase && st_r.reg_addr == lds_pkg::REG_SOFT_RESET
         && st_r.shift == lds_pkg::SOFT_RESET_KEY && !start_det && !stop_det)
        |=> st_r.ctrl1 == lds_pkg::GLOBAL_CTRL1_RESET && st_r.ctrl2 == lds_pkg::GLOBAL_CTRL2_RESET)
        else $error("reset key did not clear control registers");
    ot_hold_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (st_r.ot_seen && !st_r.ctrl2.ot_action_off) |=> !active_o)
        else $error("active while overtemperature persists");
    uv_flag_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (uv_s && !st_r.uv_seen && !st_r.ctrl2.uv_monitor_off)
        |=> st_r.flags[lds_pkg::UNDERVOLTAGE_FLAG_BIT])
        else $error("undervoltage flag not set");
    ot_flag_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (ot_s && !st_r.ot_seen && !st_r.ctrl2.ot_monitor_off)
        |=> st_r.flags[lds_pkg::OVERTEMP_FLAG_BIT])
        else $error("overtemperature flag not set");
endmodule // lds_target

// File: sim/lds_host_model.sv
// Bus master model: clocks start, stop and byte transfers on the serial port at 400 kHz
module lds_host_model #(
    parameter int QTR_CYC = 125
) (
    input wire logic clk_sys_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o,
    output logic res_valid_o,
    output logic [7:0] res_data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Clock stands high and data is released between frames
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        res_valid_o = 1'b0;
        res_data_o = 8'h00;
    end

    task automatic qwait(input int n);
        repeat (n * QTR_CYC) @(negedge clk_sys_i);
    endtask

    // Data changes only while the clock is low; sampled mid-high
    task automatic bit_cycle(input logic drive_low, output logic seen);
        sda_low_o = drive_low;
        qwait(1);
        scl_o = 1'b1;
        qwait(1);
        seen = sda_i;
        qwait(1);
        scl_o = 1'b0;
        qwait(1);
    endtask

    // Also serves as repeated start
    task automatic start_cond();
        sda_low_o = 1'b0;
        qwait(1);
        scl_o = 1'b1;
        qwait(1);
        sda_low_o = 1'b1;
        qwait(1);
        scl_o = 1'b0;
        qwait(1);
    endtask

    task automatic stop_cond();
        sda_low_o = 1'b1;
        qwait(1);
        scl_o = 1'b1;
        qwait(1);
        sda_low_o = 1'b0;
        qwait(2);
    endtask

    task automatic report(input logic [7:0] v);
        res_data_o = v;
        res_valid_o = 1'b1;
        @(negedge clk_sys_i);
        res_valid_o = 1'b0;
    endtask

    // Fewer than eight bits leaves the byte unfinished
    task automatic send_byte(input logic [7:0] b, input int nbits);
        logic s;
        for (int i = 7; i > 7 - nbits; i--) begin
            bit_cycle(~b[i], s);
        end
        if (nbits == 8) begin
            bit_cycle(1'b0, s);
            report({7'h00, s});
        end
    endtask

    task automatic recv_byte(input logic master_ack);
        logic s;
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 8; i++) begin
            bit_cycle(1'b0, s);
            v = {v[6:0], s};
        end
        bit_cycle(master_ack, s);
        report(v);
    endtask
endmodule // lds_host_model

// File: sim/tb_top.sv
// Self-checking bench for the serial target port and supervisor
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TIMEOUT_CYC = 120000;
    logic clk_sys = 1'b0;
    logic resetn;
    logic scl, host_sda_low, sda_bus, sda_o, sda_oe_n, uv, ot, active, osc, res_valid;
    logic [7:0] gcf, gcs, res_data, ctrl2_val;
    logic [7:0] notes[$];
    logic [31:0] rnd_state;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;

    initial forever #2.5 clk_sys = ~clk_sys;

    // Open-drain line with pull-up
    assign sda_bus = (host_sda_low === 1'b1 || (sda_oe_n === 1'b0 && sda_o === 1'b0)) ? 1'b0 : 1'b1;

    lds_target dut_u (
        .clk_sys_i(clk_sys), .resetn_i(resetn), .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n), .undervoltage_i(uv), .overtemp_i(ot), .active_o(active),
        .osc_run_o(osc), .global_control_first_o(gcf), .global_control_second_o(gcs)
    );

    lds_host_model host_u (
        .clk_sys_i(clk_sys), .sda_i(sda_bus), .scl_o(scl), .sda_low_o(host_sda_low),
        .res_valid_o(res_valid), .res_data_o(res_data)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic addr_phase(input logic [7:0] ra);
        notes.push_back(8'h00);
        host_u.start_cond();
        host_u.send_byte({lds_pkg::TARGET_ADDR, 1'b0}, 8);
        notes.push_back(8'h00);
        host_u.send_byte(ra, 8);
    endtask

    task automatic write_seq(input logic [7:0] ra, input logic [7:0] data[$]);
        addr_phase(ra);
        foreach (data[i]) begin
            notes.push_back(8'h00);
            host_u.send_byte(data[i], 8);
        end
        host_u.stop_cond();
        repeat (20) @(negedge clk_sys);
    endtask

    task automatic read_seq(input logic [7:0] ra, input logic [7:0] exp[$]);
        addr_phase(ra);
        notes.push_back(8'h00);
        host_u.start_cond();
        host_u.send_byte({lds_pkg::TARGET_ADDR, 1'b1}, 8);
        foreach (exp[i]) begin
            notes.push_back(exp[i]);
            host_u.recv_byte(i != exp.size() - 1);
        end
        host_u.stop_cond();
    endtask

    // Every finished byte from the master model is matched to the oldest note
    always @(posedge clk_sys) begin
        if (res_valid === 1'b1) begin
            check("serial byte", res_data, notes.size() != 0 ? notes.pop_front() : ~res_data);
        end
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYC) begin
            mismatches++;
            conclude();
        end
    end

    initial begin
        resetn = 1'b0;
        uv = 1'b0;
        ot = 1'b0;
        rnd_state = 32'h20fb;
        repeat (12) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (100) @(negedge clk_sys);
        check("active", {7'h00, active}, 8'h00);
        check("osc", {7'h00, osc}, 8'h00);
        check("ctrl1", gcf, lds_pkg::GLOBAL_CTRL1_RESET);
        check("ctrl2", gcs, lds_pkg::GLOBAL_CTRL2_RESET);
        read_seq(lds_pkg::REG_EVENT_FLAGS, '{8'(1 << lds_pkg::POWER_UP_FLAG_BIT), 8'h00});
        // Foreign address must be left unanswered
        notes.push_back(8'h01);
        host_u.start_cond();
        host_u.send_byte({lds_pkg::TARGET_ADDR ^ 7'h01, 1'b0}, 8);
        host_u.stop_cond();
        rnd_state = lfsr_next(rnd_state);
        ctrl2_val = 8'(1 << lds_pkg::UV_ACTION_OFF_BIT) | {4'h0, rnd_state[3:0]};
        // Burst runs over the read-only flags and the unmapped place into 0x04
        write_seq(lds_pkg::REG_GLOBAL_CTRL1, '{8'h01, rnd_state[15:8], rnd_state[23:16], ctrl2_val});
        check("active", {7'h00, active}, 8'h01);
        check("osc", {7'h00, osc}, 8'h01);
        check("ctrl1", gcf, 8'h01);
        check("ctrl2", gcs, ctrl2_val);
        uv = 1'b1;
        repeat (60) @(negedge clk_sys);
        check("active", {7'h00, active}, 8'h01);
        ot = 1'b1;
        for (int i = 0; i < 60 && active !== 1'b0; i++) @(negedge clk_sys);
        check("active", {7'h00, active}, 8'h00);
        check("ctrl1", gcf, 8'h00);
        uv = 1'b0;
        ot = 1'b0;
        repeat (10) @(negedge clk_sys);
        read_seq(lds_pkg::REG_EVENT_FLAGS, '{8'(1 << lds_pkg::UNDERVOLTAGE_FLAG_BIT)
            | 8'(1 << lds_pkg::OVERTEMP_FLAG_BIT)});
        // Reset key, then a byte for control 1 cut short by a stop
        addr_phase(lds_pkg::REG_SOFT_RESET);
        notes.push_back(8'h00);
        host_u.send_byte(lds_pkg::SOFT_RESET_KEY, 8);
        host_u.send_byte(8'hff, 4);
        host_u.stop_cond();
        repeat (20) @(negedge clk_sys);
        check("ctrl2", gcs, 8'h00);
        check("ctrl1", gcf, 8'h00);
        write_seq(lds_pkg::REG_GLOBAL_CTRL2, '{8'hff});
        check("ctrl2", gcs, 8'h00);
        // Undervoltage with default protection settings
        uv = 1'b1;
        repeat (10) @(negedge clk_sys);
        check("active", {7'h00, active}, 8'h00);
        uv = 1'b0;
        check("pending", 8'(notes.size()), 8'h00);
        conclude();
    end
endmodule // tb_top
